// >>> dctm_timer.sv
// Purpose: Compare-and-match logic of a two-channel 8-bit timer.
// Assumes: COUNT_TICK carries the selected count clock as a one-cycle enable.
// Notes:   Registers sit on a byte-wide CPU bus; read data follows one cycle later.
//
// Overview of operation
// - Compare A match raises interrupt, toggles output
// - Compare A works in every mode
// - Reset clears both compare registers to zero
// - Compare B used only in PWM, carrier
// - PWM compare B match toggles output, no interrupt
// - Carrier compare B match interrupts and clears counter
// - Running compare B writes wait for old match
// - Write colliding with match keeps compare B
// - Carrier mode only on channel one
// - Run enable low stops and clears counter
// - Level bit sets idle output low or high

`timescale 1ns/1ps
`default_nettype none

module dctm_timer #(
  parameter int unsigned CH = dctm_pkg::NUM_CH  // Channel count
) (
  input  wire logic          CLK,            // System clock, 125 MHz
  input  wire logic          SYS_RST,        // Asynchronous reset, active high
  input  wire logic [15:0]   BUS_ADDR,       // CPU byte address
  input  wire logic [7:0]    BUS_WDATA,      // CPU write data
  input  wire logic          BUS_WR,         // Write strobe, one cycle
  input  wire logic          BUS_RD,         // Read strobe, one cycle
  output logic      [7:0]    BUS_RDATA,      // Read data, valid the cycle after BUS_RD
  input  wire logic [CH-1:0] COUNT_TICK,     // Selected count clock per channel
  output logic      [CH-1:0] TIMER_OUT_PIN,  // Timer output per channel
  output logic      [CH-1:0] MATCH_IRQ       // Interrupt request pulse per channel
);

  // ============================================================
  // State
  // ============================================================
  typedef struct packed {
    logic [CH-1:0][7:0] compare_a;      // First compare register per channel
    logic [CH-1:0][7:0] mode;           // timer_mode_reg per channel
    logic [CH-1:0][7:0] count;          // 8-bit counter per channel
    logic [CH-1:0]      out_ff;         // Output flip-flop per channel
    logic [CH-1:0]      pin;            // Registered pin value
    logic [CH-1:0]      irq;            // Registered interrupt pulse
    logic [7:0]         rdata;          // Registered read data
  } dctm_state_t;

  dctm_state_t st_q;  // Registered state
  dctm_state_t st_d;  // Next state

  // Per-channel views of the second compare register
  logic [CH-1:0][7:0] cmpb_active;  // Value the comparator uses
  logic [CH-1:0][7:0] cmpb_shadow;  // Value returned to reads
  logic [CH-1:0]      cmpb_wr;      // Byte write to compare_b of a channel
  logic [CH-1:0]      cmpb_match;   // Compare B match event on a tick

  // ============================================================
  // Address decode helpers
  // ============================================================
  // Compare A address of a channel
  function automatic logic [15:0] addr_cmpa(input int unsigned ch);
    addr_cmpa = (ch == 0) ? dctm_pkg::ADDR_COMPARE_A_CH0 : dctm_pkg::ADDR_COMPARE_A_CH1;
  endfunction

  // Compare B address of a channel
  function automatic logic [15:0] addr_cmpb(input int unsigned ch);
    addr_cmpb = (ch == 0) ? dctm_pkg::ADDR_COMPARE_B_CH0 : dctm_pkg::ADDR_COMPARE_B_CH1;
  endfunction

  // Mode register address of a channel
  function automatic logic [15:0] addr_mode(input int unsigned ch);
    addr_mode = (ch == 0) ? dctm_pkg::ADDR_MODE_CH0 : dctm_pkg::ADDR_MODE_CH1;
  endfunction

  // Effective mode: carrier on a channel without it falls back to interval,
  // and the reserved code is treated the same way so the counter never hangs
  function automatic dctm_pkg::dctm_mode_t eff_mode(input logic [7:0] m,
                                                    input int unsigned ch);
    logic [1:0] code;
    code = m[dctm_pkg::BIT_MODE_HI:dctm_pkg::BIT_MODE_LO];
    case (code)
      2'b10: begin
        eff_mode = dctm_pkg::DCTM_MODE_PWM;
      end
      2'b01: begin
        eff_mode = (ch == dctm_pkg::CARRIER_CH) ? dctm_pkg::DCTM_MODE_CARRIER
                                                : dctm_pkg::DCTM_MODE_INTERVAL;
      end
      default: begin
        eff_mode = dctm_pkg::DCTM_MODE_INTERVAL;
      end
    endcase
  endfunction

  // ============================================================
  // Second compare registers, one buffered instance per channel
  // ============================================================
  genvar gi;
  generate
    for (gi = 0; gi < CH; gi++) begin : g_cmpb
      // Write strobe for this channel's compare_b
      assign cmpb_wr[gi] = BUS_WR && (BUS_ADDR == addr_cmpb(gi));

      // Compare B only matters in PWM and carrier modes
      assign cmpb_match[gi] = st_q.mode[gi][dctm_pkg::BIT_RUN_ENABLE] && COUNT_TICK[gi]
                              && (st_q.count[gi] == cmpb_active[gi])
                              && (eff_mode(st_q.mode[gi], gi) != dctm_pkg::DCTM_MODE_INTERVAL);

      dctm_cmpb_buf u_cmpb (
        .clk     (CLK),
        .rst     (SYS_RST),
        .wr_en   (cmpb_wr[gi]),
        .wdata   (BUS_WDATA),
        .running (st_q.mode[gi][dctm_pkg::BIT_RUN_ENABLE]),
        .match   (cmpb_match[gi]),
        .active  (cmpb_active[gi]),
        .shadow  (cmpb_shadow[gi])
      );
    end
  endgenerate

  // ============================================================
  // Next-state logic: bus, counters, outputs
  // ============================================================
  always_comb begin
    logic                 run;      // Channel counting
    logic                 tick;     // Count clock edge this cycle
    logic                 match_a;  // Counter equals compare A
    logic                 toggle;   // Output flip-flop inverts
    logic                 clr;      // Counter returns to zero
    logic                 irq;      // Interrupt this tick
    dctm_pkg::dctm_mode_t md;       // Effective mode
    run     = 1'b0;
    tick    = 1'b0;
    match_a = 1'b0;
    toggle  = 1'b0;
    clr     = 1'b0;
    irq     = 1'b0;
    md      = dctm_pkg::DCTM_MODE_INTERVAL;
    st_d    = st_q;
    st_d.rdata = 8'h00;

    for (int unsigned i = 0; i < CH; i++) begin
      run     = st_q.mode[i][dctm_pkg::BIT_RUN_ENABLE];
      tick    = COUNT_TICK[i];
      md      = eff_mode(st_q.mode[i], i);
      // Compare A is checked in every mode
      match_a = (st_q.count[i] == st_q.compare_a[i]);
      toggle  = 1'b0;
      clr     = 1'b0;
      irq     = 1'b0;

      // Bus writes to compare A; holding it while running is up to software
      if (BUS_WR && (BUS_ADDR == addr_cmpa(i))) begin
        st_d.compare_a[i] = BUS_WDATA;
      end

      // Mode writes: while running only the run enable may change, the
      // other fields are frozen so a stray write cannot break a period
      if (BUS_WR && (BUS_ADDR == addr_mode(i))) begin
        if (run) begin
          st_d.mode[i][dctm_pkg::BIT_RUN_ENABLE] = BUS_WDATA[dctm_pkg::BIT_RUN_ENABLE];
        end else begin
          st_d.mode[i] = BUS_WDATA & dctm_pkg::MODE_STORED_MASK;
        end
      end

      if (!run) begin
        // Stopped: counter held at zero, output back to default
        st_d.count[i]  = dctm_pkg::RST_COUNT;
        st_d.out_ff[i] = st_q.mode[i][dctm_pkg::BIT_OUT_LEVEL];
      end else if (tick) begin
        case (md)
          dctm_pkg::DCTM_MODE_PWM: begin
            if (match_a) begin
              // Period end: interrupt, invert, restart
              irq    = 1'b1;
              toggle = 1'b1;
              clr    = 1'b1;
            end else if (cmpb_match[i]) begin
              // Duty end: invert only, no interrupt
              toggle = 1'b1;
            end
          end
          dctm_pkg::DCTM_MODE_CARRIER: begin
            if (match_a) begin
              irq    = 1'b1;
              toggle = 1'b1;
              clr    = 1'b1;
            end else if (cmpb_match[i]) begin
              // Carrier half period: interrupt and clear together
              irq    = 1'b1;
              toggle = 1'b1;
              clr    = 1'b1;
            end
          end
          default: begin
            if (match_a) begin
              irq    = 1'b1;
              toggle = 1'b1;
              clr    = 1'b1;
            end
          end
        endcase

        // Counter advance or clear on the count clock
        if (clr) begin
          st_d.count[i] = dctm_pkg::RST_COUNT;
        end else begin
          st_d.count[i] = st_q.count[i] + 8'h01;
        end
        // Output flip-flop inversion
        if (toggle) begin
          st_d.out_ff[i] = ~st_q.out_ff[i];
        end
      end

      // Interrupt is a single-cycle pulse
      st_d.irq[i] = irq;

      // Pin shows the flip-flop only while output is enabled; a disabled
      // output reads low so no half-built waveform reaches the board
      st_d.pin[i] = st_q.mode[i][dctm_pkg::BIT_OUT_ENABLE] & st_d.out_ff[i];

      // Read decode; compare B returns the last written value, which may
      // differ from the active one until the pending transfer happens
      if (BUS_RD) begin
        if (BUS_ADDR == addr_cmpa(i)) begin
          st_d.rdata = st_q.compare_a[i];
        end else if (BUS_ADDR == addr_cmpb(i)) begin
          st_d.rdata = cmpb_shadow[i];
        end else if (BUS_ADDR == addr_mode(i)) begin
          st_d.rdata = st_q.mode[i];
        end
      end
    end
  end

  // ============================================================
  // State register
  // ============================================================
  // Reset clears compare A, mode and counters
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q.compare_a <= {CH{dctm_pkg::RST_COMPARE}};
      st_q.mode      <= {CH{dctm_pkg::RST_MODE}};
      st_q.count     <= {CH{dctm_pkg::RST_COUNT}};
      st_q.out_ff    <= '0;
      st_q.pin       <= '0;
      st_q.irq       <= '0;
      st_q.rdata     <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  // ============================================================
  // Outputs, each straight from a flip-flop
  // ============================================================
  assign BUS_RDATA     = st_q.rdata;
  assign TIMER_OUT_PIN = st_q.pin;
  assign MATCH_IRQ     = st_q.irq;

endmodule // dctm_timer

`default_nettype wire

// >>> dctm_pkg.sv
// Purpose: Shared constants and types of the dual-channel compare-match timer.
// Assumes: Byte-wide memory-mapped register accesses from the CPU.
// Notes:   Every offset, field position and reset value lives here once.

// ============================================================
// Package
// ============================================================
package dctm_pkg;

  // Channel count and the one channel that owns the carrier mode
  localparam int unsigned NUM_CH     = 2;
  localparam int unsigned CARRIER_CH = 1;

  // Register byte addresses
  localparam logic [15:0] ADDR_COMPARE_A_CH0 = 16'hff18;
  localparam logic [15:0] ADDR_COMPARE_B_CH0 = 16'hff19;
  localparam logic [15:0] ADDR_COMPARE_A_CH1 = 16'hff1a;
  localparam logic [15:0] ADDR_COMPARE_B_CH1 = 16'hff1b;
  localparam logic [15:0] ADDR_MODE_CH0      = 16'hff69;
  localparam logic [15:0] ADDR_MODE_CH1      = 16'hff6c;

  // Values after reset
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [7:0] RST_COUNT   = 8'h00;

  // Field positions inside timer_mode_reg
  localparam int unsigned BIT_RUN_ENABLE = 7;
  localparam int unsigned BIT_MODE_HI    = 3;
  localparam int unsigned BIT_MODE_LO    = 2;
  localparam int unsigned BIT_OUT_LEVEL  = 1;
  localparam int unsigned BIT_OUT_ENABLE = 0;

  // Bits of timer_mode_reg that hold storage; clock select reads as zero
  localparam logic [7:0] MODE_STORED_MASK = 8'h8f;

  // Operating modes
  typedef enum logic [1:0] {
    DCTM_MODE_INTERVAL = 2'b00,
    DCTM_MODE_CARRIER  = 2'b01,
    DCTM_MODE_PWM      = 2'b10,
    DCTM_MODE_RSVD     = 2'b11
  } dctm_mode_t;

endpackage : dctm_pkg

// >>> dctm_cmpb_buf.sv
// Purpose: Buffered second compare register of one timer channel.
// Assumes: Writes and match events are single-cycle strobes on CLK.
// Notes:   Running writes wait in a latch until the old value matches.

`timescale 1ns/1ps
`default_nettype none

module dctm_cmpb_buf (
  input  wire logic       clk,       // System clock
  input  wire logic       rst,       // Asynchronous reset, active high
  input  wire logic       wr_en,     // Byte write to this register
  input  wire logic [7:0] wdata,     // Write data
  input  wire logic       running,   // Channel run enable
  input  wire logic       match,     // Counter equals the active value on a tick
  output logic      [7:0] active,    // Value used by the comparator
  output logic      [7:0] shadow     // Value last written, returned on reads
);

  // ============================================================
  // State
  // ============================================================
  typedef struct packed {
    logic [7:0] active;   // Comparator value
    logic [7:0] shadow;   // Latched write value
    logic       pending;  // Latch holds a value not yet transferred
  } dctm_cmpb_state_t;

  dctm_cmpb_state_t st_q;  // Registered state
  dctm_cmpb_state_t st_d;  // Next state

  // ============================================================
  // Next-state logic
  // ============================================================
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.shadow = wdata;
      if (!running) begin
        // Stopped timer: value takes effect at once
        st_d.active  = wdata;
        st_d.pending = 1'b0;
      end else begin
        // Running timer: park the value until the old one matches
        st_d.pending = 1'b1;
      end
    end else if (match && st_q.pending) begin
      // Transfer on a match with the old value
      st_d.active  = st_q.shadow;
      st_d.pending = 1'b0;
    end
    // A write in the match cycle leaves active untouched
  end

  // Registers cleared to zero by system reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '{active: dctm_pkg::RST_COMPARE, shadow: dctm_pkg::RST_COMPARE, pending: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign active = st_q.active;
  assign shadow = st_q.shadow;

endmodule // dctm_cmpb_buf

`default_nettype wire

// >>> dctm_timer_monitor.sv
// Purpose: Port-level checks of the two-channel compare-match timer.
// Assumes: Mode writes while running alter only the run_enable bit.
// Notes:   Mode and compare_a ch0 are shadowed from bus writes.

`timescale 1ns/1ps
`default_nettype none

module dctm_timer_chk #(
  parameter int unsigned CH = 2  // Channel count
) (
  input wire logic          CLK,
  input wire logic          SYS_RST,
  input wire logic [15:0]   BUS_ADDR,
  input wire logic [7:0]    BUS_WDATA,
  input wire logic          BUS_WR,
  input wire logic          BUS_RD,
  input wire logic [7:0]    BUS_RDATA,
  input wire logic [CH-1:0] COUNT_TICK,
  input wire logic [CH-1:0] TIMER_OUT_PIN,
  input wire logic [CH-1:0] MATCH_IRQ
);
  // ============================================================
  // Shadow registers
  // ============================================================
  logic [7:0] m0_q;   // Mode of channel zero
  logic [7:0] m1_q;   // Mode of channel one
  logic [7:0] ca0_q;  // compare_a of channel zero

  // Running writes reach only the run bit, so keep the low bits then
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      m0_q  <= 8'h00;
      m1_q  <= 8'h00;
      ca0_q <= 8'h00;
    end else if (BUS_WR) begin
      if (BUS_ADDR == dctm_pkg::ADDR_MODE_CH0) m0_q <= m0_q[7] ? {BUS_WDATA[7], m0_q[6:0]} : BUS_WDATA;
      if (BUS_ADDR == dctm_pkg::ADDR_MODE_CH1) m1_q <= m1_q[7] ? {BUS_WDATA[7], m1_q[6:0]} : BUS_WDATA;
      if (BUS_ADDR == dctm_pkg::ADDR_COMPARE_A_CH0) ca0_q <= BUS_WDATA;
    end
  end

  // ============================================================
  // Assertions
  // ============================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // Stopped for two samples with an unchanged mode
  sequence s_idle0;
    !m0_q[7] ##1 (!m0_q[7] && $stable(m0_q));
  endsequence
  sequence s_idle1;
    !m1_q[7] ##1 (!m1_q[7] && $stable(m1_q));
  endsequence

  a_irq_tick_zero: assert property (MATCH_IRQ[0] |-> $past(COUNT_TICK[0]))
    else $error("irq zero without a tick");
  a_irq_tick_one: assert property (MATCH_IRQ[1] |-> $past(COUNT_TICK[1]))
    else $error("irq one without a tick");
  a_pin_cause_zero: assert property ($changed(TIMER_OUT_PIN[0]) |-> $past(COUNT_TICK[0])
    || $past(BUS_WR) || $past(BUS_WR, 2) || $past(BUS_WR, 3)) else $error("pin zero moved");
  a_pin_cause_one: assert property ($changed(TIMER_OUT_PIN[1]) |-> $past(COUNT_TICK[1])
    || $past(BUS_WR) || $past(BUS_WR, 2) || $past(BUS_WR, 3)) else $error("pin one moved");
  a_stop_quiet_zero: assert property (!m0_q[7] |=> !MATCH_IRQ[0])
    else $error("irq zero while stopped");
  a_stop_quiet_one: assert property (!m1_q[7] |=> !MATCH_IRQ[1])
    else $error("irq one while stopped");
  a_stop_level_zero: assert property (s_idle0 |-> TIMER_OUT_PIN[0] == (m0_q[1] & m0_q[0]))
    else $error("pin zero not at level");
  a_stop_level_one: assert property (s_idle1 |-> TIMER_OUT_PIN[1] == (m1_q[1] & m1_q[0]))
    else $error("pin one not at level");
  a_read_cmpa_zero: assert property (BUS_RD && BUS_ADDR == dctm_pkg::ADDR_COMPARE_A_CH0
    |=> BUS_RDATA == ca0_q) else $error("compare_a read wrong");

endmodule // dctm_timer_chk

bind dctm_timer dctm_timer_chk #(.CH(CH)) dctm_timer_chk_inst (
  .CLK(CLK), .SYS_RST(SYS_RST), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
  .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA), .COUNT_TICK(COUNT_TICK),
  .TIMER_OUT_PIN(TIMER_OUT_PIN), .MATCH_IRQ(MATCH_IRQ)
);

`default_nettype wire

// >>> dctm_timer_tb.sv
// Purpose: Self-checking bench of the two-channel compare-match timer.
// Assumes: Inputs change at the falling edge; ticks run every cycle.
// Notes:   Counts irq pulses and pin toggles over fixed tick runs.

`timescale 1ns/1ps
`default_nettype none

module dual_compare_8bit_timer_match_tb;
  // ============================================================
  // Signals
  // ============================================================
  logic        clk = 1'b0;      // 125 MHz
  logic        sys_rst = 1'b1;  // Held at start
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic [1:0]  tick = 2'b00;
  logic [1:0]  pin;
  logic [1:0]  irq;
  int          failures = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          n_irq;           // Irq pulses in last run
  int          n_tog;           // Pin toggles in last run
  int          gap;             // Cycles from irq to next toggle
  logic [7:0]  rv;

  always #4 clk = ~clk;

  dctm_timer #(.CH(2)) dctm_timer_inst (
    .CLK(clk), .SYS_RST(sys_rst), .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr),
    .BUS_RD(rd), .BUS_RDATA(rdata), .COUNT_TICK(tick), .TIMER_OUT_PIN(pin),
    .MATCH_IRQ(irq)
  );

  // ============================================================
  // Helpers
  // ============================================================
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Data is valid in the cycle after the taking edge
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask

  // Gives n ticks on one channel, one per cycle, counting results
  task automatic run_ticks(input int ch, input int n);
    logic prev;
    n_irq = 0;
    n_tog = 0;
    prev = pin[ch];
    for (int i = 0; i <= n; i++) begin
      @(negedge clk);
      if (irq[ch] === 1'b1) n_irq++;
      if (pin[ch] !== prev) n_tog++;
      prev = pin[ch];
      tick[ch] = (i < n);
    end
  endtask

  // Bounded wait for an irq, then cycles until the compare_b toggle
  task automatic measure_gap();
    int   k;
    logic prev;
    k = 0;
    while (irq[0] !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    prev = pin[0];
    gap = 0;
    do begin
      @(negedge clk);
      gap++;
    end while (pin[0] === prev && gap < 40);
  endtask

  // ============================================================
  // Scenarios
  // ============================================================
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      rd_reg(dctm_pkg::ADDR_COMPARE_A_CH0 + 16'(i), rv);
      check("compare reset", rv, dctm_pkg::RST_COMPARE);
      wr_reg(dctm_pkg::ADDR_COMPARE_A_CH0 + 16'(i), 8'ha5);
      rd_reg(dctm_pkg::ADDR_COMPARE_A_CH0 + 16'(i), rv);
      check("compare rw", rv, 8'ha5);
    end
    $display("t_reset done");
  endtask

  // Carrier code on channel zero must act as interval; compare_b ignored
  task automatic t_interval();
    wr_reg(dctm_pkg::ADDR_COMPARE_A_CH0, 8'h02);
    wr_reg(dctm_pkg::ADDR_COMPARE_B_CH0, 8'h01);
    wr_reg(dctm_pkg::ADDR_MODE_CH0, 8'h85);
    run_ticks(0, 13);
    check("interval irq", 8'(n_irq), 8'h04);
    check("interval toggles", 8'(n_tog), 8'h04);
    wr_reg(dctm_pkg::ADDR_MODE_CH0, 8'h00);
    wr_reg(dctm_pkg::ADDR_MODE_CH0, 8'h03);
    repeat (2) @(negedge clk);
    check("level high", 8'(pin[0]), 8'h01);
    wr_reg(dctm_pkg::ADDR_MODE_CH0, 8'h81);
    run_ticks(0, 2);
    check("restart count", 8'(n_irq), 8'h00);
    wr_reg(dctm_pkg::ADDR_MODE_CH0, 8'h00);
    // Reserved mode code must also run as a plain interval timer
    wr_reg(dctm_pkg::ADDR_MODE_CH0, 8'h8d);
    run_ticks(0, 6);
    check("reserved irq", 8'(n_irq), 8'h02);
    check("reserved toggles", 8'(n_tog), 8'h02);
    wr_reg(dctm_pkg::ADDR_MODE_CH0, 8'h00);
    $display("t_interval done");
  endtask

  task automatic t_pwm();
    wr_reg(dctm_pkg::ADDR_COMPARE_A_CH0, 8'h09);
    wr_reg(dctm_pkg::ADDR_COMPARE_B_CH0, 8'h03);
    wr_reg(dctm_pkg::ADDR_MODE_CH0, 8'h89);
    run_ticks(0, 20);
    check("pwm irq", 8'(n_irq), 8'h02);
    check("pwm toggles", 8'(n_tog), 8'h04);
    // Let an edge pass so the tick is not driven twice in one step
    @(negedge clk);
    tick[0] = 1'b1;
    measure_gap();
    check("pwm gap", 8'(gap), 8'h04);
    wr_reg(dctm_pkg::ADDR_COMPARE_B_CH0, 8'h05);
    measure_gap();
    check("old gap", 8'(gap), 8'h04);
    measure_gap();
    check("new gap", 8'(gap), 8'h06);
    tick[0] = 1'b0;
    rd_reg(dctm_pkg::ADDR_COMPARE_B_CH0, rv);
    check("compare_b read", rv, 8'h05);
    wr_reg(dctm_pkg::ADDR_MODE_CH0, 8'h00);
    $display("t_pwm done");
  endtask

  // Compare_b match clears the counter and interrupts on channel one
  task automatic t_carrier();
    wr_reg(dctm_pkg::ADDR_COMPARE_A_CH1, 8'h09);
    wr_reg(dctm_pkg::ADDR_COMPARE_B_CH1, 8'h02);
    wr_reg(dctm_pkg::ADDR_MODE_CH1, 8'h85);
    run_ticks(1, 12);
    check("carrier irq", 8'(n_irq), 8'h04);
    check("carrier toggles", 8'(n_tog), 8'h04);
    // Counter now sits on compare_b; a write on the matching tick must wait
    run_ticks(1, 2);
    @(negedge clk);
    addr = dctm_pkg::ADDR_COMPARE_B_CH1;
    wdata = 8'h05;
    wr = 1'b1;
    tick[1] = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    tick[1] = 1'b0;
    check("collision irq", 8'(irq[1]), 8'h01);
    run_ticks(1, 3);
    check("collision kept", 8'(n_irq), 8'h01);
    run_ticks(1, 6);
    check("collision moved", 8'(n_irq), 8'h01);
    wr_reg(dctm_pkg::ADDR_MODE_CH1, 8'h00);
    $display("t_carrier done");
  endtask

  // A reset in mid-run clears the compare registers and the pins
  task automatic t_reset_mid();
    wr_reg(dctm_pkg::ADDR_MODE_CH1, 8'h03);
    wr_reg(dctm_pkg::ADDR_MODE_CH1, 8'h83);
    check("run level", 8'(pin[1]), 8'h01);
    @(negedge clk);
    tick[1] = 1'b1;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    tick[1] = 1'b0;
    check("reset pins", 8'(pin), 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd_reg(dctm_pkg::ADDR_COMPARE_A_CH0 + 16'(i), rv);
      check("compare mid reset", rv, dctm_pkg::RST_COMPARE);
    end
    $display("t_reset_mid done");
  endtask

  // ============================================================
  // Run control
  // ============================================================
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_interval();
    t_pwm();
    t_carrier();
    t_reset_mid();
    wrap_up();
  end

endmodule // dual_compare_8bit_timer_match_tb

`default_nettype wire
